// >>> dv/break_unit_monitor.sv
// checker on the user break unit ports
// assumes bind onto user_break_unit, one clock domain pclk
`timescale 1ns/1ps
`default_nettype none
module break_unit_monitor (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       bus_valid,
	input wire logic       bus_is_dma,
	input wire logic       bus_is_fetch,
	input wire logic [1:0] bus_fetch_kind,
	input wire logic       exec_valid,
	input wire logic       exec_cancel,
	input wire logic       break_irq_req,
	input wire logic       break_trigger_out,
	input wire logic       irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_RESET_IDLE:
	assert property ($rose(presetn) |-> break_trigger_out && !irq
		&& !break_irq_req) else $error("outputs active after reset");
	AST_TRIG_CAUSE:
	assert property ($fell(break_trigger_out) |-> $past(bus_valid))
		else $error("trigger fell without a bus cycle");
	AST_TRIG_MAX:
	assert property (!bus_valid[*8] ##1 !bus_valid[*8] |=> break_trigger_out)
		else $error("trigger low beyond sixteen clocks");
	AST_REQ_TRIG:
	assert property (break_irq_req && !$past(exec_valid) |->
		!break_trigger_out) else $error("data break without trigger");
	AST_FETCH_WAITS:
	assert property (bus_valid && bus_is_fetch && !exec_valid &&
		bus_fetch_kind == break_pkg::FETCH_NORMAL |=> !break_irq_req)
		else $error("fetch break before execution");
	AST_DEST_QUIET:
	assert property (bus_valid && !exec_valid &&
		bus_fetch_kind == break_pkg::FETCH_BRANCH_DEST |=> !break_irq_req)
		else $error("break on branch destination fetch");
	AST_DMA_FETCH:
	assert property (bus_valid && bus_is_dma && bus_is_fetch && !exec_valid
		|=> !break_irq_req) else $error("break on dma fetch");
	AST_CANCEL_DROP:
	assert property (exec_cancel && !bus_valid ##1 !bus_valid && !exec_valid
		##1 exec_valid && !bus_valid |=> !break_irq_req)
		else $error("cancelled break still requested");
endmodule
`default_nettype wire

// >>> dv/core_model.sv
// behavioural cpu, dma and interrupt controller beside the unit
// assumes the bench calls cyc and exec; drives just after rising edges
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic   pclk,
	input  wire logic   break_irq_req,
	output logic        bus_valid,
	output logic        bus_is_dma,
	output logic        bus_is_fetch,
	output logic        bus_is_write,
	output logic [1:0]  bus_size,
	output logic [31:0] bus_addr,
	output logic [1:0]  bus_fetch_kind,
	output logic        bus_fetch_pair,
	output logic        exec_valid,
	output logic        exec_second,
	output logic        exec_cancel
);
	int req_cnt = 0;
	initial begin
		{bus_valid, bus_is_dma, bus_is_fetch, bus_is_write} = 4'h0;
		{bus_size, bus_fetch_kind, bus_fetch_pair} = 5'h00;
		{exec_valid, exec_second, exec_cancel} = 3'h0;
		bus_addr = 32'h00000000;
	end
	// interrupt controller: counts requests it accepts
	always @(posedge pclk) begin
		if (break_irq_req === 1'b1) begin
			req_cnt++;
		end
	end
	task automatic cyc(input logic dma, input logic fetch, input logic wr,
		input logic [1:0] kind, input logic pair, input logic [31:0] a);
		@(posedge pclk);
		bus_valid <= 1'b1;
		bus_is_dma <= dma;
		bus_is_fetch <= fetch;
		bus_is_write <= wr;
		bus_size <= 2'h2;
		bus_fetch_kind <= kind;
		bus_fetch_pair <= pair;
		bus_addr <= a;
		@(posedge pclk);
		bus_valid <= 1'b0;
		// released bus shows no stale address
		bus_addr <= ~a;
	endtask
	task automatic exec(input logic v, input logic s, input logic c);
		@(posedge pclk);
		exec_valid <= v;
		exec_second <= s;
		exec_cancel <= c;
		@(posedge pclk);
		{exec_valid, exec_second, exec_cancel} <= 3'h0;
	endtask
endmodule
`default_nettype wire

// >>> dv/user_break_unit_bench.sv
// self-checking bench for the user break unit
// assumes break_pkg, user_break_unit, core_model, break_unit_monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module user_break_unit_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd, bus_addr;
	logic        pready, pslverr, break_irq_req, break_trigger_out, irq, err;
	logic        bus_valid, bus_is_dma, bus_is_fetch, bus_is_write;
	logic [1:0]  bus_size, bus_fetch_kind;
	logic        bus_fetch_pair, exec_valid, exec_second, exec_cancel;
	int          num_errors = 0;
	int          n_tests = 0;
	int          low_cnt = 0;
	int          cyc_cnt = 0;
	int          l0, r0;
	localparam logic [31:0] HIT = 32'h00000404;
	user_break_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_valid(bus_valid), .bus_is_dma(bus_is_dma),
		.bus_is_fetch(bus_is_fetch), .bus_is_write(bus_is_write),
		.bus_size(bus_size), .bus_addr(bus_addr),
		.bus_fetch_kind(bus_fetch_kind), .bus_fetch_pair(bus_fetch_pair),
		.exec_valid(exec_valid), .exec_second(exec_second),
		.exec_cancel(exec_cancel), .break_irq_req(break_irq_req),
		.break_trigger_out(break_trigger_out), .irq(irq));
	core_model core (.pclk(pclk), .break_irq_req(break_irq_req),
		.bus_valid(bus_valid), .bus_is_dma(bus_is_dma),
		.bus_is_fetch(bus_is_fetch), .bus_is_write(bus_is_write),
		.bus_size(bus_size), .bus_addr(bus_addr),
		.bus_fetch_kind(bus_fetch_kind), .bus_fetch_pair(bus_fetch_pair),
		.exec_valid(exec_valid), .exec_second(exec_second),
		.exec_cancel(exec_cancel));
	initial begin
		forever #50 pclk = ~pclk;
	end
	// trigger low-time tally and hang guard
	always @(posedge pclk) begin
		cyc_cnt++;
		if (break_trigger_out === 1'b0) low_cnt++;
		if (cyc_cnt == 20000) begin
			num_errors++;
			give_verdict;
		end
	end
	task automatic give_verdict;
		if (num_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic mark;
		l0 = low_cnt;
		r0 = core.req_cnt;
	endtask
	// negative lo skips the trigger count
	task automatic check(input int lo, input int rq);
		repeat (24) @(posedge pclk);
		if (lo >= 0) `CHK(low_cnt - l0, lo)
		`CHK(core.req_cnt - r0, rq)
	endtask
	task automatic hit;
		core.cyc(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, HIT);
	endtask
	task automatic t_reset;
		logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
		`CHK(break_trigger_out, 1'b1)
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			`CHK(rd, rv[i])
		end
		apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'h64);
		mark;
		hit;
		check(0, 0);
		apb(1'b1, break_pkg::ADDR_STANDBY_CTRL, 32'h0);
		apb(1'b1, break_pkg::ADDR_BREAK_ADDRESS, HIT);
		apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'h64);
	endtask
	task automatic t_width;
		int w [4] = '{1, 4, 8, 16};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, break_pkg::ADDR_BREAK_CONTROL, 32'(i) << 1);
			mark;
			hit;
			check(w[i], 1);
		end
		mark;
		hit;
		hit;
		check(18, 2);
		apb(1'b1, break_pkg::ADDR_BREAK_CONTROL, 32'h7);
		mark;
		hit;
		check(16, 0);
	endtask
	task automatic t_sel;
		int p [3] = '{6, 4, 2};
		apb(1'b1, break_pkg::ADDR_BREAK_CONTROL, 32'h0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'h64 & ~(32'h3 << p[i]));
			mark;
			hit;
			check(0, 0);
		end
		apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'hE8);
		mark;
		core.cyc(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, HIT);
		check(1, 1);
	endtask
	task automatic t_fetch;
		apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'h54);
		mark;
		core.cyc(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, HIT);
		check(1, 0);
		mark;
		core.exec(1'b1, 1'b0, 1'b0);
		check(0, 1);
		// branch, two overruns, then destination; only the break target
		mark;
		core.cyc(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 32'h00000400);
		core.cyc(1'b0, 1'b1, 1'b0, 2'h1, 1'b0, 32'h00000402);
		core.cyc(1'b0, 1'b1, 1'b0, 2'h1, 1'b0, HIT);
		core.cyc(1'b0, 1'b1, 1'b0, 2'h2, 1'b0, 32'h00000600);
		core.exec(1'b1, 1'b0, 1'b0);
		check(1, 0);
		mark;
		core.cyc(1'b0, 1'b1, 1'b0, 2'h2, 1'b0, HIT);
		check(1, 0);
		mark;
		core.cyc(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, HIT);
		core.exec(1'b0, 1'b0, 1'b1);
		core.exec(1'b1, 1'b0, 1'b0);
		check(1, 0);
		mark;
		core.cyc(1'b0, 1'b1, 1'b0, 2'h0, 1'b1, HIT);
		apb(1'b1, break_pkg::ADDR_BREAK_ADDRESS, 32'h00000500);
		core.exec(1'b1, 1'b1, 1'b0);
		check(1, 1);
		apb(1'b1, break_pkg::ADDR_BREAK_ADDRESS, HIT);
		apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'h74);
		mark;
		core.cyc(1'b0, 1'b1, 1'b0, 2'h1, 1'b0, HIT);
		check(1, 1);
		apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'h94);
		mark;
		core.cyc(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, HIT);
		check(-1, 0);
	endtask
	task automatic t_irq;
		apb(1'b1, break_pkg::ADDR_BREAK_CYCLE_TYPE, 32'h64);
		apb(1'b0, break_pkg::ADDR_IRQ_STATUS, 32'h0);
		apb(1'b1, break_pkg::ADDR_IRQ_MASK, 32'h1);
		mark;
		hit;
		check(1, 1);
		`CHK(irq, 1'b1)
		apb(1'b0, break_pkg::ADDR_IRQ_STATUS, 32'h0);
		`CHK(rd, 32'h00000003)
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, break_pkg::ADDR_IRQ_MASK, 32'h0);
		mark;
		hit;
		check(1, 1);
		`CHK(irq, 1'b0)
		apb(1'b0, 8'h1C, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h00000000})
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_width;
		t_sel;
		t_fetch;
		t_irq;
		give_verdict;
	end
endmodule
bind user_break_unit break_unit_monitor mon (.pclk(pclk),
	.presetn(presetn), .bus_valid(bus_valid), .bus_is_dma(bus_is_dma),
	.bus_is_fetch(bus_is_fetch), .bus_fetch_kind(bus_fetch_kind),
	.exec_valid(exec_valid), .exec_cancel(exec_cancel),
	.break_irq_req(break_irq_req), .break_trigger_out(break_trigger_out),
	.irq(irq));
`default_nettype wire

// >>> verilog/break_pkg.sv
// package for the user break match and trigger unit
// assumes a 32-bit apb register bus and one 10 MHz clock

package break_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_BREAK_ADDRESS    = 8'h00;
	localparam logic [7:0] ADDR_BREAK_ADDR_MASK  = 8'h04;
	localparam logic [7:0] ADDR_BREAK_CYCLE_TYPE = 8'h08;
	localparam logic [7:0] ADDR_BREAK_CONTROL    = 8'h0C;
	localparam logic [7:0] ADDR_STANDBY_CTRL     = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS       = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK         = 8'h18;

	// ------------------------------------------------------------
	// field layouts
	// ------------------------------------------------------------
	// cycle type register: [7:6] cpu/dma, [5:4] fetch/data,
	// [3:2] read/write, [1:0] size
	localparam int CT_CP_POS   = 6;
	localparam int CT_ID_POS   = 4;
	localparam int CT_RW_POS   = 2;
	localparam int CT_SZ_POS   = 0;
	localparam int CT_WIDTH    = 8;
	localparam int CTRL_WIDTH  = 3;
	localparam int CTRL_DIS    = 0;
	localparam int CTRL_CKS_LO = 1;
	localparam int CTRL_CKS_HI = 2;
	localparam int STBY_BIT    = 0;
	localparam int STAT_WIDTH  = 2;
	localparam int STAT_BREAK  = 0;
	localparam int STAT_TRIG   = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0]         RST_ADDRESS = 32'h00000000;
	localparam logic [31:0]         RST_MASK    = 32'h00000000;
	localparam logic [CT_WIDTH-1:0] RST_CTYPE   = 8'h00;
	localparam logic [CTRL_WIDTH-1:0] RST_CTRL  = 3'h0;
	localparam logic                RST_STBY    = 1'b1;

	// ------------------------------------------------------------
	// timing: trigger widths in clocks
	// ------------------------------------------------------------
	localparam logic [4:0] TRIG_W0 = 5'h01;
	localparam logic [4:0] TRIG_W1 = 5'h04;
	localparam logic [4:0] TRIG_W2 = 5'h08;
	localparam logic [4:0] TRIG_W3 = 5'h10;

	// selector pair encodings
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_A    = 2'h1;
	localparam logic [1:0] SEL_B    = 2'h2;
	localparam logic [1:0] SEL_BOTH = 2'h3;

	// bus cycle kinds seen on the monitor port
	typedef enum logic [1:0] {
		FETCH_NORMAL,
		FETCH_OVERRUN,
		FETCH_BRANCH_DEST
	} fetch_kind_t;

endpackage

// >>> verilog/user_break_unit.sv
// user break unit: compares monitored cpu/dma bus cycles with break
// conditions, raises a break request and an active-low trigger pulse.
// assumes the core marks overrun and non-delay destination fetches,
// and confirms execution of a fetched instruction on exec_valid.

`timescale 1ns/1ps
`default_nettype none

module user_break_unit (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bus_valid,
	input  wire logic        bus_is_dma,
	input  wire logic        bus_is_fetch,
	input  wire logic        bus_is_write,
	input  wire logic [1:0]  bus_size,
	input  wire logic [31:0] bus_addr,
	input  wire logic [1:0]  bus_fetch_kind,
	input  wire logic        bus_fetch_pair,
	input  wire logic        exec_valid,
	input  wire logic        exec_second,
	input  wire logic        exec_cancel,
	output logic             break_irq_req,
	output logic             break_trigger_out,
	output logic             irq
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0]                      break_address_reg;
	logic [31:0]                      addr_mask_r;
	logic [break_pkg::CT_WIDTH-1:0]   break_cycle_type_reg;
	logic [break_pkg::CTRL_WIDTH-1:0] break_control_reg;
	logic                             standby_r;
	logic [break_pkg::STAT_WIDTH-1:0] status_r;
	logic [break_pkg::STAT_WIDTH-1:0] mask_r;
	logic [4:0]                       trig_cnt_r;
	logic                             fetch_pend_r;
	logic                             pair_pend_r;
	logic                             break_irq_disable;
	logic [1:0]                       trig_sel;
	logic                             wr_en;
	logic                             rd_en;
	logic                             addr_ok;
	logic                             data_hit;
	logic                             fetch_hit;
	logic                             fetch_match;
	logic                             trig_event;
	logic                             brk_event;
	logic                             active;

	assign break_irq_disable = break_control_reg[break_pkg::CTRL_DIS];
	assign trig_sel = {break_control_reg[break_pkg::CTRL_CKS_HI],
	                   break_control_reg[break_pkg::CTRL_CKS_LO]};
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	// gated clock modelled as masking new matches and condition register writes; pending flags still run
	assign active = ~standby_r;

	// fetch kind flags, decoded once; only the overrun flag also reaches the trigger
	logic kind_normal;
	logic kind_overrun;
	logic kind_dest;
	assign kind_normal  = bus_fetch_kind == 2'(break_pkg::FETCH_NORMAL);
	assign kind_overrun = bus_fetch_kind == 2'(break_pkg::FETCH_OVERRUN);
	assign kind_dest    = bus_fetch_kind == 2'(break_pkg::FETCH_BRANCH_DEST);

	// ------------------------------------------------------------
	// match decode
	// ------------------------------------------------------------
	function automatic logic pair_hit(input logic [1:0] sel,
	                                  input logic       is_b);
		pair_hit = (sel == break_pkg::SEL_BOTH) |
		           ((sel == break_pkg::SEL_A) & ~is_b) |
		           ((sel == break_pkg::SEL_B) & is_b);
	endfunction

	function automatic logic cond_hit(input logic [7:0] ct,
	                                  input logic       dma,
	                                  input logic       dat,
	                                  input logic       wr,
	                                  input logic [1:0] sz);
		logic [1:0] szsel;
		szsel = ct[break_pkg::CT_SZ_POS +: 2];
		// a 00 pair never matches through pair_hit
		cond_hit = pair_hit(ct[break_pkg::CT_CP_POS +: 2], dma) &
		           pair_hit(ct[break_pkg::CT_ID_POS +: 2], dat) &
		           pair_hit(ct[break_pkg::CT_RW_POS +: 2], wr) &
		           ((szsel == break_pkg::SEL_NONE) | (szsel == sz));
	endfunction

	// pulse length minus one, loaded into the down counter on a match
	function automatic logic [4:0] trig_load(input logic [1:0] sel);
		case (sel)
			2'h0:    trig_load = break_pkg::TRIG_W0 - 5'h01;
			2'h1:    trig_load = break_pkg::TRIG_W1 - 5'h01;
			2'h2:    trig_load = break_pkg::TRIG_W2 - 5'h01;
			default: trig_load = break_pkg::TRIG_W3 - 5'h01;
		endcase
	endfunction

	assign addr_ok = ((bus_addr ^ break_address_reg) & ~addr_mask_r) ==
	                 32'h00000000;

	// dma never fetches, so a dma+fetch condition cannot hit
	assign fetch_hit = active & bus_valid & bus_is_fetch & ~bus_is_dma &
	                   addr_ok &
	                   cond_hit(break_cycle_type_reg, 1'b0, 1'b0, 1'b0,
	                            bus_size);

	// an overrun fetch also counts as a data read
	assign data_hit = active & bus_valid & addr_ok &
	                  ((~bus_is_fetch &
	                    cond_hit(break_cycle_type_reg, bus_is_dma, 1'b1,
	                             bus_is_write, bus_size)) |
	                   (bus_is_fetch &
	                    kind_overrun &
	                    cond_hit(break_cycle_type_reg, 1'b0, 1'b1, 1'b0,
	                             bus_size)));

	// destination fetch of a non-delay branch never breaks
	assign fetch_match = fetch_hit & ~kind_dest;

	// overrun fetch still pulses the trigger
	assign trig_event = data_hit | fetch_hit;

	// fetch break waits for confirmed execution; overruns never confirm
	assign brk_event = data_hit |
	                   (exec_valid & ~exec_second & fetch_pend_r) |
	                   (exec_valid & exec_second & pair_pend_r);

	// ------------------------------------------------------------
	// pending fetch matches
	// ------------------------------------------------------------
	// the pair flag is captured at the paired fetch, so a later rewrite
	// of the condition cannot cancel a break on the second instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_pend_r <= 1'b0;
			pair_pend_r  <= 1'b0;
		end else if (exec_cancel) begin
			// exception accepted at decode drops the pending break; the
			// break is lost rather than replayed after the handler returns
			fetch_pend_r <= 1'b0;
			pair_pend_r  <= 1'b0;
		end else begin
			// only a normal fetch can pend; overrun and destination
			// fetches never reach execution as the targeted instruction
			if (fetch_match & kind_normal) begin
				fetch_pend_r <= ~bus_fetch_pair;
				pair_pend_r  <= bus_fetch_pair;
			end else if (exec_valid) begin
				if (exec_second)
					pair_pend_r <= 1'b0;
				else
					fetch_pend_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// break request
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			break_irq_req <= 1'b0;
		else
			break_irq_req <= brk_event & ~break_irq_disable;
	end

	// ------------------------------------------------------------
	// trigger pulse
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_cnt_r        <= 5'h00;
			break_trigger_out <= 1'b1;
		end else if (trig_event) begin
			// a new match restarts the count from this cycle, so a
			// burst of matches stretches one low pulse instead of
			// giving a glitch high between them
			trig_cnt_r <= trig_load(trig_sel);
			break_trigger_out <= 1'b0;
		end else if (trig_cnt_r != 5'h00) begin
			trig_cnt_r <= trig_cnt_r - 5'h01;
		end else begin
			break_trigger_out <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// writes to condition registers are ignored while in standby
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_address_reg    <= break_pkg::RST_ADDRESS;
			addr_mask_r          <= break_pkg::RST_MASK;
			break_cycle_type_reg <= break_pkg::RST_CTYPE;
			break_control_reg    <= break_pkg::RST_CTRL;
			mask_r               <= 2'h0;
		end else if (wr_en & active) begin
			case (paddr)
				break_pkg::ADDR_BREAK_ADDRESS:
					break_address_reg <= pwdata;
				break_pkg::ADDR_BREAK_ADDR_MASK:
					addr_mask_r <= pwdata;
				break_pkg::ADDR_BREAK_CYCLE_TYPE:
					break_cycle_type_reg <= pwdata[break_pkg::CT_WIDTH-1:0];
				break_pkg::ADDR_BREAK_CONTROL:
					break_control_reg <= pwdata[break_pkg::CTRL_WIDTH-1:0];
				break_pkg::ADDR_IRQ_MASK:
					mask_r <= pwdata[break_pkg::STAT_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	// the standby bit is the one register still writable in standby,
	// otherwise software could never wake the unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			standby_r <= break_pkg::RST_STBY;
		else if (wr_en & (paddr == break_pkg::ADDR_STANDBY_CTRL))
			standby_r <= pwdata[break_pkg::STBY_BIT];
	end

	// ------------------------------------------------------------
	// interrupt status: read clears, a new event wins over the clear
	// ------------------------------------------------------------
	logic                             stat_clr;
	logic [break_pkg::STAT_WIDTH-1:0] stat_evt;

	// the clear lands only on the access edge, so one read clears once
	assign stat_clr = rd_en & (paddr == break_pkg::ADDR_IRQ_STATUS);
	assign stat_evt[break_pkg::STAT_BREAK] = brk_event;
	assign stat_evt[break_pkg::STAT_TRIG]  = trig_event;

	// one sticky bit per event; set beats clear so that an event in
	// the cycle of the read is reported on the next read, not lost
	genvar gi;
	generate
		for (gi = 0; gi < break_pkg::STAT_WIDTH; gi++) begin : g_stat
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					status_r[gi] <= 1'b0;
				else if (stat_evt[gi])
					status_r[gi] <= 1'b1;
				else if (stat_clr)
					status_r[gi] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status_r & mask_r);
	end

	// ------------------------------------------------------------
	// apb read mux
	// ------------------------------------------------------------
	logic [31:0] rd_word;
	logic        rd_miss;
	logic        setup_ph;

	// unmapped offsets read as zero and flag an error
	always_comb begin
		rd_word = 32'h00000000;
		rd_miss = 1'b0;
		case (paddr)
			break_pkg::ADDR_BREAK_ADDRESS:
				rd_word = break_address_reg;
			break_pkg::ADDR_BREAK_ADDR_MASK:
				rd_word = addr_mask_r;
			break_pkg::ADDR_BREAK_CYCLE_TYPE:
				rd_word = {24'h000000, break_cycle_type_reg};
			break_pkg::ADDR_BREAK_CONTROL:
				rd_word = {29'h00000000, break_control_reg};
			break_pkg::ADDR_STANDBY_CTRL:
				rd_word = {31'h00000000, standby_r};
			break_pkg::ADDR_IRQ_STATUS:
				rd_word = {30'h00000000, status_r};
			break_pkg::ADDR_IRQ_MASK:
				rd_word = {30'h00000000, mask_r};
			default:
				rd_miss = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// apb answer, zero wait states
	// ------------------------------------------------------------
	// registered at the setup edge so that the answer stands for
	// exactly the one access cycle that follows
	assign setup_ph = psel & ~penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & rd_miss;
			prdata  <= setup_ph ? rd_word : 32'h00000000;
		end
	end

endmodule

`default_nettype wire
